// ### rtl/area_timing_params.svh
`ifndef AREA_TIMING_PARAMS_SVH
`define AREA_TIMING_PARAMS_SVH

// register byte offsets on the AXI4-Lite port
`define OFS_WAIT_TIMING_CTRL 8'h00
`define OFS_ACCESS_STATUS 8'h04
`define OFS_ACCESS_LENGTH 8'h08

// fields of area_wait_timing_control
`define FLD_WRITE_WAIT_HI 18
`define FLD_WRITE_WAIT_LO 16
`define FLD_SETUP_HI 12
`define FLD_SETUP_LO 11
`define FLD_READ_WAIT_HI 10
`define FLD_READ_WAIT_LO 7
`define FLD_WAIT_IGNORE 6
`define FLD_HOLD_HI 1
`define FLD_HOLD_LO 0

// bits software may change; everything else reads as zero
`define CTRL_WRITABLE_MASK 32'h0007_1fc3
`define CTRL_RESET_VALUE 32'h0000_0500

// fields of the status register
`define STAT_BUSY 0
`define STAT_EXT_STRETCH 1
`define STAT_RDATA_LO 16

// timing in mclk cycles; one bus cycle is two mclk periods
`define HALF_CYCLES_PER_BUS_CYCLE 7'h02
`define EXT_WAIT_EXTEND_LOAD 7'h01

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### rtl/area_timing_pkg.sv
package area_timing_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } access_state_t;

  typedef logic [1:0] delay_sel_t;
  typedef logic [3:0] read_wait_code_t;
  typedef logic [2:0] write_wait_code_t;
  typedef logic [4:0] wait_cycles_t;
  typedef logic [6:0] half_count_t;

endpackage

// ### rtl/axil_reg_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "area_timing_params.svh"

module axil_reg_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire aw_take = s_axi_awvalid && !aw_have_q && !bvalid_q;
  wire w_take = s_axi_wvalid && !w_have_q && !bvalid_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire ar_take = s_axi_arvalid && !rvalid_q;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_en = do_write;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read data is sampled at the address handshake, answered one cycle later
  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? rd_data : 32'h0000_0000;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // axil_reg_port

`default_nettype wire

// ### rtl/area_access_wait_timing.sv
`timescale 1ns/10ps
`default_nettype none
`include "area_timing_params.svh"

module area_access_wait_timing
  import area_timing_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [23:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic [15:0] acc_rdata,
  output logic bus_clk,
  output logic [23:0] ext_addr,
  output logic area_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [15:0] ext_data_in,
  input wire logic ext_wait_n
);

  access_state_t state_q, state_d;
  logic [31:0] ctrl_q;
  half_count_t cnt_q;
  logic bus_clk_q;
  logic ready_q;
  logic done_q;
  logic [15:0] rdata_q;
  logic [23:0] addr_q;
  logic sel_n_q;
  logic rd_n_q;
  logic wr_n_q;
  logic [15:0] dout_q;
  logic oe_q;
  logic is_write_q;
  logic stretch_q;
  logic [15:0] length_q;
  logic [15:0] length_run_q;
  // timing snapshot so a register write mid-access cannot tear a cycle
  delay_sel_t hold_sel_q;
  wait_cycles_t waits_q;
  logic ignore_q;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_data;

  axil_reg_port u_port (
    .mclk(mclk),
    .reset(reset),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // register decode
  assign wr_hit = (wr_addr == `OFS_WAIT_TIMING_CTRL) ||
                  (wr_addr == `OFS_ACCESS_STATUS) ||
                  (wr_addr == `OFS_ACCESS_LENGTH);
  assign rd_hit = (rd_addr == `OFS_WAIT_TIMING_CTRL) ||
                  (rd_addr == `OFS_ACCESS_STATUS) ||
                  (rd_addr == `OFS_ACCESS_LENGTH);
  wire busy = (state_q != ST_IDLE);
  wire [31:0] status_word = {rdata_q, 14'h0000, stretch_q, busy};
  assign rd_data =
    (rd_addr == `OFS_WAIT_TIMING_CTRL) ? ctrl_q :
    (rd_addr == `OFS_ACCESS_STATUS) ? status_word :
    (rd_addr == `OFS_ACCESS_LENGTH) ? {16'h0000, length_q} : 32'h0000_0000;

  wire [31:0] byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  // reserved bits 5:2 are never stored, so they read back as zero
  wire [31:0] keep_mask = byte_mask & `CTRL_WRITABLE_MASK;
  wire [31:0] ctrl_d = (ctrl_q & ~keep_mask) | (wr_data & keep_mask);
  wire ctrl_we = wr_en && (wr_addr == `OFS_WAIT_TIMING_CTRL);

  // field views of the control register
  wire delay_sel_t setup_sel = ctrl_q[`FLD_SETUP_HI:`FLD_SETUP_LO];
  wire delay_sel_t hold_sel = ctrl_q[`FLD_HOLD_HI:`FLD_HOLD_LO];
  wire read_wait_code_t rw_code =
    ctrl_q[`FLD_READ_WAIT_HI:`FLD_READ_WAIT_LO];
  wire write_wait_code_t ww_code =
    ctrl_q[`FLD_WRITE_WAIT_HI:`FLD_WRITE_WAIT_LO];
  wire ignore_ext = ctrl_q[`FLD_WAIT_IGNORE];

  function automatic wait_cycles_t read_waits(input read_wait_code_t c);
    unique case (c)
      4'h0: read_waits = 5'h00;
      4'h1: read_waits = 5'h01;
      4'h2: read_waits = 5'h02;
      4'h3: read_waits = 5'h03;
      4'h4: read_waits = 5'h04;
      4'h5: read_waits = 5'h05;
      4'h6: read_waits = 5'h06;
      4'h7: read_waits = 5'h08;
      4'h8: read_waits = 5'h0a;
      4'h9: read_waits = 5'h0c;
      4'ha: read_waits = 5'h0e;
      4'hb: read_waits = 5'h12;
      4'hc: read_waits = 5'h18;
      // prohibited codes: longest setting, the safe side for slow parts
      default: read_waits = 5'h18;
    endcase
  endfunction

  wire wait_cycles_t rd_waits = read_waits(rw_code);
  wire wait_cycles_t wr_waits = (ww_code == 3'h0) ? rd_waits :
                                (5'(ww_code) - 5'h01);
  wire wait_cycles_t req_waits = acc_write ? wr_waits : rd_waits;

  // all delays in half bus cycles, i.e. mclk periods; loads are length-1
  wire half_count_t setup_load = {4'h0, setup_sel, 1'b0};
  wire half_count_t hold_load = {4'h0, hold_sel_q, 1'b0};
  wire half_count_t strobe_load = {1'b0, waits_q, 1'b1};

  // ignore bit gates the wait pin whatever the count, zero included
  wire ext_hold_off = !ext_wait_n && !ignore_q;
  wire start = acc_req && ready_q && !bus_clk_q;
  wire cnt_zero = (cnt_q == 7'h00);
  // external wait looked at only once the programmed waits are spent
  wire strobe_end = (state_q == ST_STROBE) && cnt_zero && !ext_hold_off;
  wire strobe_extend = (state_q == ST_STROBE) && cnt_zero &&
                       ext_hold_off;
  wire hold_end = (state_q == ST_HOLD) && cnt_zero;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (strobe_end) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hold_end) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  wire half_count_t cnt_d =
    start ? setup_load :
    ((state_q == ST_SETUP) && cnt_zero) ? strobe_load :
    strobe_extend ? `EXT_WAIT_EXTEND_LOAD :
    strobe_end ? hold_load :
    cnt_zero ? 7'h00 : (cnt_q - 7'h01);

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET_VALUE;
    end else if (ctrl_we) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q <= 7'h00;
      bus_clk_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bus_clk_q <= ~bus_clk_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_sel_q <= 2'b00;
      waits_q <= 5'h00;
      ignore_q <= 1'b0;
      is_write_q <= 1'b0;
      addr_q <= 24'h00_0000;
      dout_q <= 16'h0000;
    end else if (start) begin
      hold_sel_q <= hold_sel;
      waits_q <= req_waits;
      ignore_q <= ignore_ext;
      is_write_q <= acc_write;
      addr_q <= acc_addr;
      dout_q <= acc_wdata;
    end
  end

  // pin drive: select and address frame the strobe on both sides
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      if (start) begin
        sel_n_q <= 1'b0;
        oe_q <= acc_write;
      end else if (hold_end) begin
        sel_n_q <= 1'b1;
        oe_q <= 1'b0;
      end
      if ((state_q == ST_SETUP) && cnt_zero) begin
        rd_n_q <= is_write_q;
        wr_n_q <= !is_write_q;
      end else if (strobe_end) begin
        rd_n_q <= 1'b1;
        wr_n_q <= 1'b1;
      end
    end
  end

  // requester handshake and statistics
  always_ff @(posedge mclk) begin
    if (reset) begin
      ready_q <= 1'b1;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
      stretch_q <= 1'b0;
      length_q <= 16'h0000;
      length_run_q <= 16'h0000;
    end else begin
      done_q <= hold_end;
      if (start) begin
        ready_q <= 1'b0;
        length_run_q <= 16'h0000;
      end else if (hold_end) begin
        ready_q <= 1'b1;
        length_q <= length_run_q + 16'h0001;
      end else if (busy) begin
        length_run_q <= length_run_q + 16'h0001;
      end
      if (strobe_end && !is_write_q) begin
        rdata_q <= ext_data_in;
      end
      // shows a strobe currently held by the external wait pin
      if (strobe_extend) begin
        stretch_q <= 1'b1;
      end else if (strobe_end) begin
        stretch_q <= 1'b0;
      end
    end
  end

  assign acc_ready = ready_q;
  assign acc_done = done_q;
  assign acc_rdata = rdata_q;
  assign bus_clk = bus_clk_q;
  assign ext_addr = addr_q;
  assign area_select_n = sel_n_q;
  assign read_strobe_n = rd_n_q;
  assign write_strobe_n = wr_n_q;
  assign ext_data_out = dout_q;
  assign ext_data_oe = oe_q;

endmodule // area_access_wait_timing

`default_nettype wire

// ### tb/area_timing_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module area_timing_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic acc_ready,
  input wire logic acc_done,
  input wire logic [23:0] ext_addr,
  input wire logic area_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic ext_data_oe
);
  logic [7:0] ph_cnt_q;
  logic stb_q;
  wire logic stb_n = read_strobe_n & write_strobe_n;

  // length of the current phase, restarted at every strobe edge
  always_ff @(posedge mclk) begin
    stb_q <= stb_n;
    if (reset || area_select_n)
      ph_cnt_q <= 8'h00;
    else if (stb_n != stb_q)
      ph_cnt_q <= 8'h01;
    else
      ph_cnt_q <= ph_cnt_q + 8'h01;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // select sampled low, then high: the access has just ended
  sequence sel_closed;
    !area_select_n ##1 area_select_n;
  endsequence

  chk_setup_odd: assert property ($fell(stb_n) |-> ph_cnt_q[0] && ph_cnt_q <= 8'h07)
    else $error("setup phase length wrong");
  chk_strobe_even: assert property ($rose(stb_n) |-> !ph_cnt_q[0] && ph_cnt_q >= 8'h02)
    else $error("strobe length wrong");
  chk_hold_odd: assert property ($rose(area_select_n) |-> ph_cnt_q[0] && ph_cnt_q <= 8'h07)
    else $error("hold phase length wrong");
  chk_done_pulse: assert property (sel_closed |-> acc_done ##1 !acc_done)
    else $error("done pulse missing");
  chk_ready_idle: assert property (acc_ready |-> area_select_n && stb_n)
    else $error("ready during access");
  chk_oe_window: assert property (ext_data_oe |-> !area_select_n && read_strobe_n)
    else $error("data driven outside write");
  chk_one_strobe: assert property (!stb_n |-> !area_select_n && (read_strobe_n || write_strobe_n))
    else $error("strobe outside select");
  chk_addr_stable: assert property (!area_select_n && $past(area_select_n) == 1'b0 |-> $stable(ext_addr))
    else $error("address moved in access");
  chk_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // area_timing_checker

bind area_access_wait_timing area_timing_checker area_timing_checker_inst (
  .mclk(mclk), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .acc_ready(acc_ready), .acc_done(acc_done), .ext_addr(ext_addr),
  .area_select_n(area_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .ext_data_oe(ext_data_oe)
);

`default_nettype wire

// ### tb/sram_model.sv
`timescale 1ns/10ps
`default_nettype none

module sram_model (
  input wire logic mclk,
  input wire logic [23:0] ext_addr,
  input wire logic area_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic [7:0] wait_len,
  output logic [15:0] ext_data_in,
  output logic ext_wait_n
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  logic [7:0] cnt_q;
  logic wr_q;
  wire logic rd_on = !area_select_n && !read_strobe_n;
  wire logic stb_on = rd_on || (!area_select_n && !write_strobe_n);

  // released bus shows the inverse, so stale data cannot pass as good
  assign ext_data_in = rd_on ? mem[ext_addr[7:0]] : ~last_q;
  // wait held for wait_len cycles from strobe start
  assign ext_wait_n = !(stb_on && cnt_q < wait_len);

  always_ff @(posedge mclk) begin
    last_q <= ext_data_in;
    wr_q <= write_strobe_n;
    cnt_q <= stb_on ? cnt_q + 8'h01 : 8'h00;
    if (write_strobe_n && !wr_q && ext_data_oe)
      mem[ext_addr[7:0]] <= ext_data_out;
  end
endmodule // sram_model

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "area_timing_params.svh"

`define CHK(nm, exp, got) \
  begin \
    if ((got) !== (exp)) begin \
      $display("FAIL %s exp %h got %h", nm, exp, got); \
      n_mismatch++; \
    end \
    n_compared++; \
  end

module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic acc_req = 1'b0, acc_write = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, wait_len = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [23:0] acc_addr = 24'h0;
  logic [15:0] acc_wdata = 16'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, acc_ready, acc_done, bus_clk, area_select_n;
  logic read_strobe_n, write_strobe_n, ext_data_oe, ext_wait_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_seen;
  logic [15:0] acc_rdata, ext_data_out, ext_data_in;
  logic [23:0] ext_addr;
  logic [34:0] rd_q [$];
  logic [16:0] acc_q [$];
  logic [31:0] rnd = 32'h9f8b;
  logic [7:0] wtab [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
  int n_mismatch = 0, n_compared = 0, cyc = 0;

  area_access_wait_timing area_access_wait_timing_inst (
    .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_done(acc_done),
    .acc_rdata(acc_rdata), .bus_clk(bus_clk), .ext_addr(ext_addr),
    .area_select_n(area_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
    .ext_wait_n(ext_wait_n)
  );

  sram_model sram_model_inst (
    .mclk(mclk), .ext_addr(ext_addr), .area_select_n(area_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .wait_len(wait_len), .ext_data_in(ext_data_in), .ext_wait_n(ext_wait_n)
  );

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // select low to select high: setup, strobe and hold phases
  function automatic logic [34:0] len_e(input logic [1:0] s,
                                        input logic [7:0] w,
                                        input logic [1:0] h);
    return {3'b100, 24'h0, 8'(2 * s + 2 * w + 2 * h + 4)};
  endfunction

  always @(posedge mclk) begin
    logic [34:0] e;
    logic [16:0] a;
    cyc++;
    if (s_axi_rvalid && s_axi_rready) begin
      rd_seen = s_axi_rdata;
      e = rd_q.pop_front();
      if (e[34])
        `CHK("axi read", e[33:0], {s_axi_rresp, s_axi_rdata})
    end
    if (acc_done) begin
      a = acc_q.pop_front();
      if (a[16])
        `CHK("acc_rdata", a[15:0], acc_rdata)
    end
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (s_axi_awready)
        aw_ok = 1'b1;
      if (s_axi_wready)
        w_ok = 1'b1;
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [34:0] e);
    rd_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic acc(input logic w, input logic [23:0] a,
                     input logic [15:0] d);
    acc_q.push_back({!w, d});
    acc_req <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    do @(posedge mclk); while (!(acc_ready && !bus_clk));
    acc_req <= 1'b0;
    do @(posedge mclk); while (!acc_done);
  endtask

  task automatic cfg(input logic [2:0] ww, input logic [1:0] s,
                     input logic [3:0] w, input logic ig,
                     input logic [1:0] h);
    axi_wr(`OFS_WAIT_TIMING_CTRL, {13'h0, ww, 3'h0, s, w, ig, 4'h0, h});
  endtask

  initial begin
    logic [3:0] i;
    logic [2:0] ww;
    logic [23:0] a;
    logic [15:0] d;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    axi_rd(`OFS_WAIT_TIMING_CTRL, {3'b100, 32'h0000_0500});
    axi_wr(`OFS_WAIT_TIMING_CTRL, 32'hfff8_e03c);
    axi_rd(`OFS_WAIT_TIMING_CTRL, {3'b100, 32'h0});
    axi_rd(8'h10, {1'b1, `RESP_SLVERR, 32'h0});
    // codes 1101 to 1111 are left out on purpose
    for (int k = 0; k < 13; k++) begin
      i = k[3:0];
      ww = k[2:0];
      rnd = lfsr(rnd);
      d = rnd[15:0];
      a = {16'h0, rnd[23:16]};
      cfg(ww, i[1:0], i, 1'b1, i[3:2]);
      acc(1'b1, a, d);
      axi_rd(`OFS_ACCESS_LENGTH, len_e(i[1:0],
             ww == 3'h0 ? wtab[k] : 8'(ww - 3'h1), i[3:2]));
      acc(1'b0, a, d);
      axi_rd(`OFS_ACCESS_LENGTH, len_e(i[1:0], wtab[k], i[3:2]));
    end
    wait_len <= 8'h06;
    cfg(3'h0, 2'h0, 4'h0, 1'b1, 2'h0);
    acc(1'b0, a, d);
    axi_rd(`OFS_ACCESS_LENGTH, len_e(2'h0, 8'h00, 2'h0));
    cfg(3'h0, 2'h0, 4'h0, 1'b0, 2'h0);
    acc(1'b0, a, d);
    // wait pin held 6 cycles: three extensions of one bus cycle each
    axi_rd(`OFS_ACCESS_LENGTH, len_e(2'h0, 8'h03, 2'h0));
    @(posedge mclk);
    `CHK("stretch", 1'b1, rd_seen[7:0] > 8'h04)
    // wait released before the programmed count ends: no stretch
    wait_len <= 8'h02;
    cfg(3'h0, 2'h0, 4'h3, 1'b0, 2'h0);
    acc(1'b0, a, d);
    axi_rd(`OFS_ACCESS_LENGTH, len_e(2'h0, 8'h03, 2'h0));
    // idle, no stretch pending, last read data in the top half
    axi_rd(`OFS_ACCESS_STATUS, {3'b100, d, 16'h0000});
    test_done();
  end
endmodule // tb_top

`default_nettype wire
